// *** gasl_pkg.sv ***
// gasl_pkg: shared constants and types of the gauge angle serial loader
// assumes: both ends and the coil converter import it whole
package gasl_pkg;

    // ----------------------------------------
    // word layout
    // ----------------------------------------
    localparam int WORD_W = 10;
    localparam int OCT_W = 3;
    localparam int STEP_W = 7;
    localparam int OCT_LSB = 7;
    localparam int MAG_W = 8;
    localparam logic [7:0] MAG_FULL = 8'h80;
    localparam logic [9:0] WORD_RST = 10'h000;
    localparam logic [3:0] LAST_BIT = 4'h9;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 100;
    localparam int SCLK_MIN_PERIOD_NS = 500;
    localparam int SCLK_HALF_CYC_I = (SCLK_MIN_PERIOD_NS / 2 + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_CYC_I);
    localparam logic [3:0] CS_GAP_CYC = 4'h8;

    // ----------------------------------------
    // host sequencer
    // ----------------------------------------
    typedef enum logic [2:0] {
        GASL_IDLE,
        GASL_LOW,
        GASL_HIGH,
        GASL_TAIL,
        GASL_GAP
    } gasl_hstate_type;

endpackage : gasl_pkg

// *** gasl_link_if.sv ***
// gasl_link_if: serial link between host and gauge device
// assumes: status line has an external pull-up, modelled here
`timescale 1ns/1ns
interface gasl_link_if;
    logic sclk;
    logic cs;
    logic sdi;
    logic sdo;
    logic oe;
    logic st_o;
    logic st_oe;
    logic drive_status_n;

    // open-drain status with pull-up
    assign drive_status_n = st_oe ? st_o : 1'b1;

    modport device (
        input sclk,
        input cs,
        input sdi,
        input oe,
        input drive_status_n,
        output sdo,
        output st_o,
        output st_oe
    );

    modport host (
        output sclk,
        output cs,
        output sdi,
        output oe,
        input sdo,
        input drive_status_n
    );
endinterface : gasl_link_if

// *** gasl_coil_conv.sv ***
// gasl_coil_conv: holding register and code-to-coil mapping
// assumes: load is a one-cycle pulse while code is stable
`timescale 1ns/1ns
module gasl_coil_conv
    import gasl_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic reset, // sync reset, active high
    input wire logic ce, // clock enable
    input wire logic load, // latch code this cycle
    input wire logic [WORD_W-1:0] code, // new angle code
    output logic [OCT_W-1:0] octant_select, // held octant
    output logic [STEP_W-1:0] octant_step, // held step
    output logic [MAG_W-1:0] sin_mag, // sine coil magnitude
    output logic [MAG_W-1:0] cos_mag, // cosine coil magnitude
    output logic sin_neg, // sine coil reversed
    output logic cos_neg, // cosine coil reversed
    output logic held_cos // cosine coil at full scale
);
    typedef struct packed {
        logic [OCT_W-1:0] oct;
        logic [STEP_W-1:0] step;
        logic [MAG_W-1:0] sin_mag;
        logic [MAG_W-1:0] cos_mag;
        logic sin_neg;
        logic cos_neg;
        logic held_cos;
    } gasl_conv_type;

    gasl_conv_type q;
    gasl_conv_type d;
    logic [OCT_W-1:0] o;
    logic [STEP_W-1:0] s;
    logic [MAG_W-1:0] vary;

    // ----------------------------------------
    // octant decode
    // ----------------------------------------
    always_comb begin
        d = q;
        o = code[WORD_W-1:OCT_LSB];
        s = code[STEP_W-1:0];
        // rising in even octants, falling in odd; linear per step
        vary = o[0] ? MAG_FULL - {1'b0, s} : {1'b0, s};
        if (load) begin
            d.oct = o;
            d.step = s;
            d.held_cos = ~(o[1] ^ o[0]);
            d.sin_neg = o[2];
            d.cos_neg = o[2] ^ o[1];
            // one coil varies, the other sits at full scale
            d.sin_mag = (o[1] ^ o[0]) ? MAG_FULL : vary;
            d.cos_mag = (o[1] ^ o[0]) ? vary : MAG_FULL;
        end
        if (reset) begin
            d = '0;
            d.held_cos = 1'b1;
            d.cos_mag = MAG_FULL;
        end
    end

    always_ff @(posedge clk) begin
        if (ce || reset) begin
            q <= d;
        end
    end

    assign octant_select = q.oct;
    assign octant_step = q.step;
    assign sin_mag = q.sin_mag;
    assign cos_mag = q.cos_mag;
    assign sin_neg = q.sin_neg;
    assign cos_neg = q.cos_neg;
    assign held_cos = q.held_cos;

endmodule : gasl_coil_conv

// *** gasl_device.sv ***
// gasl_device: gauge driver logic end of the serial link
// assumes: link sclk comes from the host and idles low outside frames;
// clk is the device's own clock; host keeps cs low a few clk cycles
// between frames so the chip select fall is seen here.
// sdo is driven at all times; the status pin needs a pull-up outside,
// this end only pulls it low.
//
// Notes on behaviour
// - one command is exactly a ten-bit word
// - top three bits octant, low seven step
// - codes map linearly onto one revolution
// - one coil varies, other at full scale
// - most significant bit is sent first
// - serial clock ignored while chip select low, except to clear after reset
// - rising serial clock samples serial input
// - falling serial clock updates serial output
// - serial output always driven, chains words
// - shifting leaves converter and outputs unchanged
// - chip select fall loads the holding register
// - status stays low until first chip select
// - outputs enabled at fall only if enabled
// - status low whenever coil outputs disabled
// - reset clears registers but sets cos_mag full, held_cos and st_oe
// - fault off until next fall, then rechecked
`timescale 1ns/1ns
module gasl_device
    import gasl_pkg::*;
(
    input wire logic clk, // device clock
    input wire logic reset, // sync reset, active high
    input wire logic ce, // clock enable
    gasl_link_if.device link, // serial link pins
    input wire logic fault, // protection trip, async
    output logic coil_en, // coil buffers enabled
    output logic [OCT_W-1:0] octant_select, // held octant
    output logic [STEP_W-1:0] octant_step, // held step
    output logic [MAG_W-1:0] sin_mag, // sine coil magnitude
    output logic [MAG_W-1:0] cos_mag, // cosine coil magnitude
    output logic sin_neg, // sine coil reversed
    output logic cos_neg, // cosine coil reversed
    output logic held_cos // cosine coil at full scale
);

    // ----------------------------------------
    // link domain state
    // ----------------------------------------
    // everything here runs on sclk alone; ce does not reach it because
    // sclk only moves while the host is framing or resetting the link
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [WORD_W-1:0] shreg;
    } gasl_lnk_type;

    gasl_lnk_type lq;
    gasl_lnk_type ld;
    logic so_q;
    logic so_d;
    logic lrst;

    // ----------------------------------------
    // reset into the link domain
    // ----------------------------------------
    // reset enters the link domain through two flops; the chain only
    // moves on sclk rises, so the host toggles sclk while reset is high
    // and the chain may still read high during the first frame after it
    assign lrst = lq.rst_sync[1];

    always_comb begin
        ld = lq;
        ld.rst_sync = {lq.rst_sync[0], reset};
        // clear only outside a frame, so a frame that starts while the
        // chain still drains keeps all of its bits
        if (lrst && !link.cs) begin
            ld.shreg = WORD_RST;
        end else if (link.cs) begin
            ld.shreg = {lq.shreg[WORD_W-2:0], link.sdi};
        end
    end

    always_ff @(posedge link.sclk) begin
        lq <= ld;
    end

    // ----------------------------------------
    // serial output on the falling edge
    // ----------------------------------------
    // sdo never floats, so a chain of ends passes the old word onwards
    // while the new one enters
    always_comb begin
        so_d = so_q;
        if (lrst && !link.cs) begin
            so_d = 1'b0;
        end else if (link.cs) begin
            so_d = lq.shreg[WORD_W-1];
        end
    end

    always_ff @(negedge link.sclk) begin
        so_q <= so_d;
    end

    assign link.sdo = so_q;

    // ----------------------------------------
    // system domain state
    // ----------------------------------------
    // pins from the link pass two flops here before any decision; the
    // word itself is taken only while cs is low and the shifter is idle
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] oe_sync;
        logic [1:0] flt_sync;
        logic cs_prev;
        logic armed;
        logic coil_en;
        logic st_oe;
        logic load;
        logic [WORD_W-1:0] code;
    } gasl_dev_type;

    gasl_dev_type q;
    gasl_dev_type d;
    logic cs_s;
    logic oe_s;
    logic flt_s;
    logic cs_fall;
    logic armed_n;

    assign cs_s = q.cs_sync[1];
    assign oe_s = q.oe_sync[1];
    assign flt_s = q.flt_sync[1];
    // cs_prev starts low, so no false fall follows reset
    assign cs_fall = q.cs_prev & ~cs_s;

    always_comb begin
        d = q;
        armed_n = q.armed;
        d.cs_sync = {q.cs_sync[0], link.cs};
        d.oe_sync = {q.oe_sync[0], link.oe};
        d.flt_sync = {q.flt_sync[0], fault};
        d.cs_prev = cs_s;
        // word stays put in the link domain while cs is low
        d.load = cs_fall;
        // word is frozen while cs is low; take it into this domain then
        if (!cs_s) begin
            d.code = lq.shreg;
        end
        // a cs fall re-arms even while the fault is held; the synced
        // fault then drops the drivers again one cycle later
        if (cs_fall) begin
            armed_n = oe_s;
        end else if (flt_s) begin
            armed_n = 1'b0;
        end
        d.armed = armed_n;
        d.coil_en = armed_n & oe_s;
        d.st_oe = ~(armed_n & oe_s);
        if (reset) begin
            d = '0;
            d.st_oe = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (ce || reset) begin
            q <= d;
        end
    end

    // ----------------------------------------
    // coil enable and status pin
    // ----------------------------------------
    // status is open drain: data held low, the enable pulls the pin down
    assign coil_en = q.coil_en;
    assign link.st_oe = q.st_oe;
    assign link.st_o = 1'b0;

    // ----------------------------------------
    // coil converter
    // ----------------------------------------
    // the converter sees the captured word in the same cycle as the load
    // pulse; the word is frozen then, so its holding register never takes a moving value
    gasl_coil_conv u_conv (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .load(q.load),
        .code(q.code),
        .octant_select(octant_select),
        .octant_step(octant_step),
        .sin_mag(sin_mag),
        .cos_mag(cos_mag),
        .sin_neg(sin_neg),
        .cos_neg(cos_neg),
        .held_cos(held_cos)
    );

endmodule : gasl_device

// *** gasl_host.sv ***
// gasl_host: host end, makes sclk, frames and shifts one word
// assumes: link sclk derived here from clk; status pin has a pull-up
`timescale 1ns/1ns
module gasl_host
    import gasl_pkg::*;
(
    input wire logic clk, // host clock
    input wire logic reset, // sync reset, active high
    input wire logic ce, // clock enable
    gasl_link_if.host link, // serial link pins
    input wire logic start, // send word, pulse
    input wire logic [WORD_W-1:0] word, // angle code to send
    input wire logic oe_req, // wanted output enable level
    output logic busy, // frame in progress
    output logic done, // frame finished, pulse
    output logic [WORD_W-1:0] rx_word, // word shifted back out
    output logic status_ok // synced status pin
);
    typedef struct packed {
        gasl_hstate_type st;
        logic [3:0] cnt;
        logic [3:0] bitn;
        logic [WORD_W-1:0] tx;
        logic [WORD_W-1:0] rx;
        logic [WORD_W-1:0] rx_word;
        logic [1:0] sdo_sync;
        logic [1:0] st_sync;
        logic sclk;
        logic cs;
        logic sdi;
        logic oe;
        logic busy;
        logic done;
        logic status_ok;
    } gasl_host_type;

    gasl_host_type q;
    gasl_host_type d;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        d = q;
        d.sdo_sync = {q.sdo_sync[0], link.sdo};
        d.st_sync = {q.st_sync[0], link.drive_status_n};
        d.status_ok = q.st_sync[1];
        d.oe = oe_req;
        d.done = 1'b0;
        d.cnt = q.cnt - 4'h1;
        case (q.st)
            GASL_IDLE: begin
                d.cnt = q.cnt;
                // link clock rests low between frames, whatever reset left
                d.sclk = 1'b0;
                if (start) begin
                    d.tx = word;
                    d.cs = 1'b1;
                    d.sdi = word[WORD_W-1];
                    d.bitn = 4'h0;
                    d.busy = 1'b1;
                    d.cnt = SCLK_HALF_CYC - 4'h1;
                    d.st = GASL_LOW;
                end
            end
            GASL_LOW: begin
                if (q.cnt == 4'h0) begin
                    d.sclk = 1'b1;
                    d.rx = {q.rx[WORD_W-2:0], q.sdo_sync[1]};
                    d.cnt = SCLK_HALF_CYC - 4'h1;
                    d.st = GASL_HIGH;
                end
            end
            GASL_HIGH: begin
                if (q.cnt == 4'h0) begin
                    d.sclk = 1'b0;
                    d.tx = {q.tx[WORD_W-2:0], 1'b0};
                    d.sdi = q.tx[WORD_W-2];
                    d.bitn = q.bitn + 4'h1;
                    d.cnt = SCLK_HALF_CYC - 4'h1;
                    d.st = (q.bitn == LAST_BIT) ? GASL_TAIL : GASL_LOW;
                end
            end
            GASL_TAIL: begin
                if (q.cnt == 4'h0) begin
                    d.cs = 1'b0;
                    d.cnt = CS_GAP_CYC - 4'h1;
                    d.st = GASL_GAP;
                end
            end
            GASL_GAP: begin
                if (q.cnt == 4'h0) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.rx_word = q.rx;
                    d.st = GASL_IDLE;
                end
            end
            default: begin
                d.st = GASL_IDLE;
            end
        endcase
        if (reset) begin
            d = '0;
            d.st = GASL_IDLE;
            // free-running sclk clears the device link logic
            d.sclk = ~q.sclk;
        end
    end

    always_ff @(posedge clk) begin
        if (ce || reset) begin
            q <= d;
        end
    end

    assign link.sclk = q.sclk;
    assign link.cs = q.cs;
    assign link.sdi = q.sdi;
    assign link.oe = q.oe;
    assign busy = q.busy;
    assign done = q.done;
    assign rx_word = q.rx_word;
    assign status_ok = q.status_ok;

endmodule : gasl_host

// *** gasl_chk.sv ***
// gasl_chk: concurrent checks on the serial link between the two ends
// assumes: instantiated beside the link interface in the bench top
`timescale 1ns/1ns
module gasl_chk (
    input wire logic clk, // system clock
    input wire logic reset, // sync reset
    input wire logic sclk, // link clock
    input wire logic cs, // chip select
    input wire logic sdi, // data to device
    input wire logic sdo, // data from device
    input wire logic oe, // output enable
    input wire logic st_oe, // status pull-down
    input wire logic drive_status_n // resolved status
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ----
    // frame bookkeeping
    // ----
    typedef struct packed {
        logic sclk;
        logic cs;
        logic [4:0] bits;
        logic seen;
    } gasl_chk_type;
    gasl_chk_type st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.sclk = sclk;
        st_d.cs = cs;
        if (cs && !st_q.cs) begin
            st_d.bits = 5'h00;
        end
        if (cs && sclk && !st_q.sclk) begin
            st_d.bits = st_q.bits + 5'h01;
        end
        if (!cs && st_q.cs) begin
            st_d.seen = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    a_sdo_quiet_idle: assert property ((!cs && $past(!cs)) |-> $stable(sdo))
        else $error("sdo moved outside a frame");
    a_sdo_on_fall: assert property ($changed(sdo) |-> $fell(sclk))
        else $error("sdo moved without a falling link clock");
    a_sdi_steady_rise: assert property ($rose(sclk) |-> $stable(sdi))
        else $error("sdi moved at a rising link clock");
    a_sclk_low_start: assert property ($rose(cs) |-> !sclk)
        else $error("frame opened with link clock high");
    a_ten_bit_word: assert property ($fell(cs) |-> st_q.bits == 5'h0a)
        else $error("frame did not carry ten bits");
    a_cs_gap_kept: assert property ($fell(cs) |-> !cs [*5])
        else $error("chip select gap too short");
    a_status_before_load: assert property (!st_q.seen |-> !drive_status_n && st_oe)
        else $error("status released before first chip select fall");
    a_status_oe_low: assert property ((!oe) [*6] |-> !drive_status_n)
        else $error("status high while output enable low");
    a_enable_needs_oe: assert property ($rose(drive_status_n) |-> oe && !cs)
        else $error("outputs enabled without output enable");
endmodule : gasl_chk

// *** tb_top.sv ***
// tb_top: self-checking bench joining host and device over the link
// assumes: both ends share clk; fault is driven by the bench
`timescale 1ns/1ns
module tb_top;
    import gasl_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic [WORD_W-1:0] word = '0;
    logic oe_req = 1'b0;
    logic fault = 1'b0;
    logic busy, done, status_ok, coil_en, sin_neg, cos_neg, held_cos;
    logic [WORD_W-1:0] rx_word;
    logic [OCT_W-1:0] octant_select;
    logic [STEP_W-1:0] octant_step;
    logic [MAG_W-1:0] sin_mag, cos_mag;
    logic en_m = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 32'h104818cf;
    int shreg_m = 0;
    int held_m = 0;

    gasl_link_if link();
    gasl_host u_gasl_host (.clk(clk), .reset(reset), .ce(1'b1), .link(link),
        .start(start), .word(word), .oe_req(oe_req), .busy(busy), .done(done),
        .rx_word(rx_word), .status_ok(status_ok));
    gasl_device u_gasl_device (.clk(clk), .reset(reset), .ce(1'b1), .link(link),
        .fault(fault), .coil_en(coil_en), .octant_select(octant_select),
        .octant_step(octant_step), .sin_mag(sin_mag), .cos_mag(cos_mag),
        .sin_neg(sin_neg), .cos_neg(cos_neg), .held_cos(held_cos));
    gasl_chk u_gasl_chk (.clk(clk), .reset(reset), .sclk(link.sclk), .cs(link.cs),
        .sdi(link.sdi), .sdo(link.sdo), .oe(link.oe), .st_oe(link.st_oe),
        .drive_status_n(link.drive_status_n));

    initial begin
        forever #50 clk = ~clk;
    end

    // ----
    // checking tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    task automatic check_conv;
        int o, s, v;
        logic hc;
        o = held_m >> 7;
        s = held_m & 127;
        v = o[0] ? 128 - s : s;
        hc = (o == 0 || o == 3 || o == 4 || o == 7);
        check(octant_select, o[2:0]);
        check(octant_step, s[6:0]);
        check(held_cos, hc);
        check(sin_mag, hc ? v : 128);
        check(cos_mag, hc ? 128 : v);
        check(sin_neg, o > 3);
        check(cos_neg, o > 1 && o < 6);
        check(coil_en, en_m);
        check(link.drive_status_n, en_m);
    endtask : check_conv

    task automatic do_reset;
        reset = 1'b1;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        shreg_m = 0;
        held_m = 0;
        en_m = 1'b0;
        repeat (2) @(negedge clk);
    endtask : do_reset

    task automatic send(input int w, input logic oe_v);
        int n;
        @(negedge clk);
        word = w[9:0];
        oe_req = oe_v;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            check(busy, 1'b1);
            if (link.cs === 1'b1) begin
                check({octant_select, octant_step}, held_m);
            end
            @(negedge clk);
            n++;
        end
        check(n < 200, 1);
        check(rx_word, shreg_m);
        shreg_m = w;
        held_m = w;
        en_m = oe_v && !fault;
        repeat (6) @(negedge clk);
        check_conv();
        check(status_ok, en_m);
    endtask : send

    // ----
    // scenarios
    // ----
    initial begin
        do_reset();
        check_conv();
        for (int i = 0; i < 8; i++) begin
            send((i << 7) | (i * 18), 1'b1);
        end
        send(1023, 1'b1);
        for (int i = 0; i < 8; i++) begin
            send($random(seed) & 1023, i[0]);
        end
        fault = 1'b1;
        repeat (6) @(negedge clk);
        en_m = 1'b0;
        check_conv();
        send(512, 1'b1);
        fault = 1'b0;
        send(300, 1'b1);
        do_reset();
        check_conv();
        send(896, 1'b1);
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule : tb_top
